/* hw/rmc_map.svh */
// reset and mode control: register indices, fields, reset values, timing
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define RMC_IDX_WDT 14'h000A
`define RMC_IDX_PEND1 14'h0012
`define RMC_IDX_MASK1 14'h0013
`define RMC_IDX_P2_FSEL 14'h1FC9
`define RMC_IDX_PORT2_DIRECTION 14'h1FCB
`define RMC_IDX_P5_FSEL 14'h1FF1
`define RMC_IDX_PORT5_DIRECTION 14'h1FF3
`define RMC_IDX_CHIP_CONFIG_ZERO 14'h2018
`define RMC_IDX_CONFIG_REGISTER_ONE 14'h2019
`define RMC_IDX_UFR 14'h201A
`define RMC_IDX_PMODE 14'h201B
`define RMC_IDX_SWRST 14'h201C
`define RMC_IDX_STATUS 14'h201D
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define RMC_EXT_BIT 6
`define RMC_PD_BIT 0
`define RMC_WDE_BIT 3
`define RMC_OFD_BIT 0
`define RMC_WDT_KEY1 8'h1E
`define RMC_WDT_KEY2 8'hE1
`define RMC_KEY_IDLE 8'h01
`define RMC_KEY_PD 8'h02
`define RMC_OP_RST 8'hFF
`define RMC_START_PC 16'h2080
// ----------------------------------------
// reset values
// ----------------------------------------
`define RMC_RST_BYTE 8'h00
`define RMC_SYNC_RST 6'h1D
// ----------------------------------------
// timing
// ----------------------------------------
`define RMC_CLK_NS 4
`define RMC_PULL_STATES 5'h10
`define RMC_VPP_LOW_NS 50
`define RMC_VPP_LOW_CYC ((`RMC_VPP_LOW_NS + `RMC_CLK_NS - 1) / `RMC_CLK_NS)
`define RMC_OSC_FAIL_NS 10000
`define RMC_OSC_FAIL_CYC (`RMC_OSC_FAIL_NS / `RMC_CLK_NS)
`endif

/* hw/rmc_pkg.sv */
// reset and mode control: shared types
package rmc_pkg;
   typedef enum logic [2:0] {
      ST_RESET, ST_FETCH0, ST_FETCH1, ST_START, ST_RUN, ST_IDLE, ST_PD
   } rmc_state_e;
endpackage

/* hw/rmc_top.sv */
// reset and mode control block with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
module rmc_top #(
   parameter int STATE_CYCLES = 2
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   input wire logic ext_int_pin,
   input wire logic vpp_pin,
   input wire logic emul_sel_pin,
   input wire logic test_entry_pin,
   input wire logic osc_in,
   output logic cfg_fetch_req,
   output logic cfg_fetch_index,
   input wire logic [7:0] cfg_fetch_data,
   input wire logic cfg_fetch_ack,
   input wire logic irq_taken,
   input wire logic other_irq_wake,
   output logic ext_irq_request,
   output logic core_reset,
   output logic first_fetch,
   output logic [15:0] first_fetch_addr,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_en,
   output logic clock_output,
   output logic emulation_mode,
   output logic test_mode,
   output logic pins_float,
   output logic [7:0] port2_function_select,
   output logic [7:0] port2_direction,
   output logic [7:0] port5_function_select,
   output logic [7:0] port5_direction
);
   import rmc_pkg::*;

   localparam int PW = (STATE_CYCLES > 1) ? $clog2(STATE_CYCLES) : 1;
   localparam logic [PW-1:0] LAST = PW'(STATE_CYCLES - 1);
   localparam logic [PW-1:0] HALF = PW'(STATE_CYCLES / 2);
   localparam logic [11:0] OSC_CYC = 12'(`RMC_OSC_FAIL_CYC);
   localparam logic [7:0] VPP_CYC = 8'(`RMC_VPP_LOW_CYC);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [5:0] sy1_reg, sy2_reg;
   logic rst_s, ext_s, vpp_s, emul_s, test_s, osc_s;

   // two flops on every asynchronous pin
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sy1_reg <= `RMC_SYNC_RST;
         sy2_reg <= `RMC_SYNC_RST;
      end else begin
         sy1_reg <= {osc_in, test_entry_pin, emul_sel_pin, vpp_pin, ext_int_pin, reset_pin_in};
         sy2_reg <= sy1_reg;
      end
   end
   assign {osc_s, test_s, emul_s, vpp_s, ext_s, rst_s} = sy2_reg;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic setup, wr_en, hit;
   logic [13:0] idx;
   logic [7:0] wb;
   assign idx = paddr[15:2];
   assign wb = pwdata[7:0];
   assign setup = psel && !penable;

   // every register sits in the low byte of its word
   always_comb begin
      case (idx)
         `RMC_IDX_WDT, `RMC_IDX_PEND1, `RMC_IDX_MASK1, `RMC_IDX_P2_FSEL, `RMC_IDX_PORT2_DIRECTION,
         `RMC_IDX_P5_FSEL, `RMC_IDX_PORT5_DIRECTION, `RMC_IDX_CHIP_CONFIG_ZERO, `RMC_IDX_CONFIG_REGISTER_ONE, `RMC_IDX_UFR,
         `RMC_IDX_PMODE, `RMC_IDX_SWRST, `RMC_IDX_STATUS: hit = (paddr[1:0] == 2'b00);
         default: hit = 1'b0;
      endcase
   end
   assign wr_en = psel && penable && pwrite && pstrb[0] && hit;

   function automatic logic wr_to(input logic [13:0] a);
      wr_to = wr_en && (idx == a);
   endfunction

   // ----------------------------------------
   // state timing and clock output
   // ----------------------------------------
   rmc_state_e st_reg, st_next;
   logic [PW-1:0] phase_reg, phase_next;
   logic clock_output_reg, clock_output_next, state_en, release_now;

   assign state_en = (phase_reg == LAST);

   // divider restarts at reset release so the clock output lines up
   always_comb begin
      phase_next = (release_now || state_en) ? '0 : phase_reg + 1'b1;
      if (st_reg == ST_PD) begin
         clock_output_next = 1'b1;
      end else begin
         clock_output_next = (phase_next >= HALF);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_reg <= '0;
         clock_output_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         clock_output_reg <= clock_output_next;
      end
   end
   assign clock_output = clock_output_reg;

   // ----------------------------------------
   // reset sources and boot sequence
   // ----------------------------------------
   logic [4:0] pull_reg, pull_next;
   logic [PW-1:0] pull_sub_reg, pull_sub_next;
   logic [7:0] vpp_cnt_reg, vpp_cnt_next;
   logic pin_prev_reg, int_req, bad_key, sw_rst, wdt_ovf, osc_fail;
   logic [7:0] chip_config_zero_reg, chip_config_zero_next, config_register_one_reg, config_register_one_next, ufr_reg;
   logic emul_reg, emul_next, test_reg, test_next, ff_reg, ff_next;
   logic osc_off_reg, osc_off_next, in_boot, ext_set, pd_ext_wake, vpp_wake;
   logic [7:0] mask_reg;

   assign in_boot = (st_reg == ST_RESET) || (st_reg == ST_FETCH0) ||
                    (st_reg == ST_FETCH1) || (st_reg == ST_START);
   assign sw_rst = wr_to(`RMC_IDX_SWRST) && (wb == `RMC_OP_RST);
   assign bad_key = wr_to(`RMC_IDX_PMODE) && (st_reg == ST_RUN) &&
                    (wb != `RMC_KEY_IDLE) && (wb != `RMC_KEY_PD);
   // internal causes; the pin itself is handled through its own edge
   assign int_req = (sw_rst || bad_key || wdt_ovf ||
                    (osc_fail && ufr_reg[`RMC_OFD_BIT])) && (st_reg != ST_RESET);
   assign release_now = (st_reg == ST_RESET) && rst_s && (pull_reg == 5'h00);
   assign pd_ext_wake = (st_reg == ST_PD) && ext_s;
   assign vpp_wake = (st_reg == ST_PD) && (vpp_cnt_reg == VPP_CYC);

   // boot, power mode and reset pin pull-down
   always_comb begin
      st_next = st_reg;
      pull_next = pull_reg;
      chip_config_zero_next = chip_config_zero_reg;
      config_register_one_next = config_register_one_reg;
      emul_next = emul_reg;
      test_next = test_reg;
      osc_off_next = osc_off_reg;
      ff_next = (st_reg == ST_START);
      // own sub-count from the start, so the pull lasts whole state times at any divider phase
      pull_sub_next = (pull_sub_reg == LAST) ? '0 : pull_sub_reg + 1'b1;
      if (((pin_prev_reg && !rst_s) || int_req) && (pull_reg == 5'h00)) begin
         pull_next = `RMC_PULL_STATES;
         pull_sub_next = '0;
      end else if ((pull_sub_reg == LAST) && (pull_reg != 5'h00)) begin
         pull_next = pull_reg - 5'h01;
      end
      case (st_reg)
         ST_RESET: begin
            chip_config_zero_next = `RMC_RST_BYTE;
            config_register_one_next = `RMC_RST_BYTE;
            osc_off_next = 1'b0;
            if (release_now) begin
               emul_next = !emul_s;
               test_next = !test_s;
               st_next = ST_FETCH0;
            end
         end
         ST_FETCH0: begin
            if (cfg_fetch_ack) begin
               chip_config_zero_next = cfg_fetch_data;
               st_next = ST_FETCH1;
            end
         end
         ST_FETCH1: begin
            if (cfg_fetch_ack) begin
               config_register_one_next = cfg_fetch_data;
               st_next = ST_START;
            end
         end
         ST_START: st_next = ST_RUN;
         ST_RUN: begin
            if (wr_to(`RMC_IDX_PMODE) && (wb == `RMC_KEY_IDLE)) begin
               st_next = ST_IDLE;
            end else if (wr_to(`RMC_IDX_PMODE) && (wb == `RMC_KEY_PD) &&
                         chip_config_zero_reg[`RMC_PD_BIT]) begin
               st_next = ST_PD;
               osc_off_next = 1'b1;
            end
         end
         ST_IDLE: begin
            if ((ext_set && mask_reg[`RMC_EXT_BIT]) || other_irq_wake) begin
               st_next = ST_RUN;
            end
         end
         ST_PD: begin
            if (pd_ext_wake) begin
               st_next = ST_RUN;
               osc_off_next = 1'b0;
            end else if (vpp_wake) begin
               st_next = ST_RUN;
            end
         end
         default: st_next = ST_RESET;
      endcase
      // pin low or an internal cause overrides any mode
      if (!rst_s || int_req) begin
         st_next = ST_RESET;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ST_RESET;
         pull_reg <= 5'h00;
         pull_sub_reg <= '0;
         pin_prev_reg <= 1'b1;
         chip_config_zero_reg <= `RMC_RST_BYTE;
         config_register_one_reg <= `RMC_RST_BYTE;
         emul_reg <= 1'b0;
         test_reg <= 1'b0;
         osc_off_reg <= 1'b0;
         ff_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         pull_reg <= pull_next;
         pull_sub_reg <= pull_sub_next;
         pin_prev_reg <= rst_s;
         chip_config_zero_reg <= chip_config_zero_next;
         config_register_one_reg <= config_register_one_next;
         emul_reg <= emul_next;
         test_reg <= test_next;
         osc_off_reg <= osc_off_next;
         ff_reg <= ff_next;
      end
   end

   // open-drain pull-down: drive low only while the count runs
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = (pull_reg != 5'h00);
   assign core_reset = in_boot;
   assign cfg_fetch_req = (st_reg == ST_FETCH0) || (st_reg == ST_FETCH1);
   assign cfg_fetch_index = (st_reg == ST_FETCH1);
   assign first_fetch = ff_reg;
   assign first_fetch_addr = `RMC_START_PC;
   assign cpu_clk_en = (st_reg == ST_RUN);
   assign periph_clk_en = (st_reg != ST_PD);
   assign osc_en = !osc_off_reg;
   assign emulation_mode = emul_reg;
   assign pins_float = emul_reg;
   assign test_mode = test_reg;

   // ----------------------------------------
   // watchdog, oscillator monitor, wake counters
   // ----------------------------------------
   logic [15:0] wdt_reg, wdt_next;
   logic wact_reg, wact_next, armed_reg, armed_next, clear_ok, wdt_tick;
   logic [11:0] osc_cnt_reg, osc_cnt_next;
   logic osc_prev_reg;

   // clock is stopped in powerdown, so the watchdog freezes there
   assign wdt_tick = wact_reg && state_en && !in_boot && (st_reg != ST_PD);
   assign wdt_ovf = wdt_tick && (wdt_reg == 16'hFFFF);
   assign clear_ok = armed_reg && wr_to(`RMC_IDX_WDT) && (wb == `RMC_WDT_KEY2) && !irq_taken;
   assign osc_fail = (osc_cnt_reg == OSC_CYC) && !osc_off_reg && (st_reg != ST_PD);

   always_comb begin
      wdt_next = wdt_reg;
      wact_next = wact_reg;
      armed_next = armed_reg;
      if (in_boot) begin
         wdt_next = 16'h0000;
         wact_next = (st_reg == ST_FETCH1) && cfg_fetch_ack &&
                     !cfg_fetch_data[`RMC_WDE_BIT];
         armed_next = 1'b0;
      end else begin
         if (clear_ok) begin
            wdt_next = 16'h0000;
            wact_next = 1'b1;
         end else if (wdt_tick) begin
            wdt_next = wdt_reg + 16'h0001;
         end
         // any other write or an interrupt between the bytes voids it
         if (irq_taken || (wr_en && !clear_ok)) begin
            armed_next = wr_to(`RMC_IDX_WDT) && (wb == `RMC_WDT_KEY1) && !irq_taken;
         end else if (clear_ok) begin
            armed_next = 1'b0;
         end
      end
      osc_cnt_next = (osc_s && !osc_prev_reg) ? 12'h000 :
                     ((osc_cnt_reg == OSC_CYC) ? osc_cnt_reg : osc_cnt_reg + 12'h001);
      if ((st_reg == ST_PD) && !vpp_s) begin
         vpp_cnt_next = (vpp_cnt_reg == VPP_CYC) ? vpp_cnt_reg : vpp_cnt_reg + 8'h01;
      end else begin
         vpp_cnt_next = 8'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wdt_reg <= 16'h0000;
         wact_reg <= 1'b0;
         armed_reg <= 1'b0;
         osc_cnt_reg <= 12'h000;
         osc_prev_reg <= 1'b0;
         vpp_cnt_reg <= 8'h00;
      end else begin
         wdt_reg <= wdt_next;
         wact_reg <= wact_next;
         armed_reg <= armed_next;
         osc_cnt_reg <= osc_cnt_next;
         osc_prev_reg <= osc_s;
         vpp_cnt_reg <= vpp_cnt_next;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   logic [7:0] pend_reg, pend_next, mask_next, ufr_next;
   logic [7:0] p2f_reg, p2f_next, p2d_reg, p2d_next, p5f_reg, p5f_next, p5d_reg, p5d_next;
   logic ext_samp_reg, ext_samp_next;

   // external pin sampled once per state time, at the end of clock-high
   assign ext_set = (state_en && clock_output_reg && ext_s && !ext_samp_reg &&
                    (st_reg != ST_PD)) || pd_ext_wake;

   always_comb begin
      ext_samp_next = state_en ? ext_s : ext_samp_reg;
      pend_next = wr_to(`RMC_IDX_PEND1) ? wb : pend_reg;
      mask_next = wr_to(`RMC_IDX_MASK1) ? wb : mask_reg;
      ufr_next = wr_to(`RMC_IDX_UFR) ? wb : ufr_reg;
      p2f_next = wr_to(`RMC_IDX_P2_FSEL) ? wb : p2f_reg;
      p2d_next = wr_to(`RMC_IDX_PORT2_DIRECTION) ? wb : p2d_reg;
      p5f_next = wr_to(`RMC_IDX_P5_FSEL) ? wb : p5f_reg;
      p5d_next = wr_to(`RMC_IDX_PORT5_DIRECTION) ? wb : p5d_reg;
      // hardware set wins over a software clear in the same cycle
      if (ext_set) begin
         pend_next[`RMC_EXT_BIT] = 1'b1;
      end
      if (in_boot) begin
         pend_next = `RMC_RST_BYTE;
         mask_next = `RMC_RST_BYTE;
         ufr_next = `RMC_RST_BYTE;
         p2f_next = `RMC_RST_BYTE;
         p2d_next = `RMC_RST_BYTE;
         p5f_next = `RMC_RST_BYTE;
         p5d_next = `RMC_RST_BYTE;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ext_samp_reg <= 1'b0;
         pend_reg <= `RMC_RST_BYTE;
         mask_reg <= `RMC_RST_BYTE;
         ufr_reg <= `RMC_RST_BYTE;
         p2f_reg <= `RMC_RST_BYTE;
         p2d_reg <= `RMC_RST_BYTE;
         p5f_reg <= `RMC_RST_BYTE;
         p5d_reg <= `RMC_RST_BYTE;
      end else begin
         ext_samp_reg <= ext_samp_next;
         pend_reg <= pend_next;
         mask_reg <= mask_next;
         ufr_reg <= ufr_next;
         p2f_reg <= p2f_next;
         p2d_reg <= p2d_next;
         p5f_reg <= p5f_next;
         p5d_reg <= p5d_next;
      end
   end
   // pending stays set while masked, so the cpu sees it later
   assign ext_irq_request = pend_reg[`RMC_EXT_BIT] && mask_reg[`RMC_EXT_BIT];
   assign port2_function_select = p2f_reg;
   assign port2_direction = p2d_reg;
   assign port5_function_select = p5f_reg;
   assign port5_direction = p5d_reg;

   // ----------------------------------------
   // apb read path
   // ----------------------------------------
   logic [7:0] rd_next;
   logic [31:0] prdata_reg;
   logic err_reg;

   // captured in setup so the access phase needs no wait state
   always_comb begin
      case (idx)
         `RMC_IDX_PEND1: rd_next = pend_reg;
         `RMC_IDX_MASK1: rd_next = mask_reg;
         `RMC_IDX_P2_FSEL: rd_next = p2f_reg;
         `RMC_IDX_PORT2_DIRECTION: rd_next = p2d_reg;
         `RMC_IDX_P5_FSEL: rd_next = p5f_reg;
         `RMC_IDX_PORT5_DIRECTION: rd_next = p5d_reg;
         `RMC_IDX_CHIP_CONFIG_ZERO: rd_next = chip_config_zero_reg;
         `RMC_IDX_CONFIG_REGISTER_ONE: rd_next = config_register_one_reg;
         `RMC_IDX_UFR: rd_next = ufr_reg;
         `RMC_IDX_STATUS: rd_next = {3'b000, test_reg, emul_reg, wact_reg,
                                     st_reg == ST_PD, st_reg == ST_IDLE};
         default: rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prdata_reg <= 32'h00000000;
         err_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= {24'h000000, (pwrite || !hit) ? 8'h00 : rd_next};
         err_reg <= !hit;
      end
   end
   assign prdata = prdata_reg;
   assign pready = psel && penable;
   assign pslverr = psel && penable && err_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   logic [4:0] pull_seen_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pull_seen_reg <= 5'h00;
      end else if (!reset_pin_oe) begin
         pull_seen_reg <= 5'h00;
      end else if (state_en) begin
         pull_seen_reg <= pull_seen_reg + 5'h01;
      end
   end

   sequence s_fetch_done;
      (st_reg == ST_FETCH1) && cfg_fetch_ack ##1 (st_reg == ST_START);
   endsequence

   a_pin_holds_reset: assert property (!rst_s |=> core_reset)
      else $error("reset pin low but core not in reset");
   a_cfg_first: assert property (s_fetch_done |=> first_fetch)
      else $error("first fetch not right after config load");
   a_pull_len: assert property ($fell(reset_pin_oe) |-> pull_seen_reg == 5'h10)
      else $error("reset pull-down not sixteen state times");
   a_bad_key: assert property (bad_key |=> core_reset && reset_pin_oe)
      else $error("illegal key did not reset");
   a_pd_gate: assert property (wr_to(`RMC_IDX_PMODE) && wb == `RMC_KEY_PD && st_reg == ST_RUN &&
      !chip_config_zero_reg[`RMC_PD_BIT] && rst_s |=> st_reg == ST_RUN)
      else $error("powerdown entered without permit");
   a_wdt_ovf: assert property (wdt_ovf |=> (st_reg == ST_RESET) && reset_pin_oe)
      else $error("watchdog overflow did not reset");
   a_wdt_sticky: assert property (wact_reg && !in_boot && !int_req && rst_s |=> wact_reg)
      else $error("watchdog stopped without reset");
   a_wdt_clear: assert property (clear_ok |=> wdt_reg == 16'h0000 && wact_reg)
      else $error("valid clear sequence ignored");
   a_vpp_wake: assert property (vpp_wake && !ext_s && rst_s |=> st_reg == ST_RUN && !osc_en)
      else $error("programming pin wake wrong");
   a_ext_pend: assert property (ext_set && rst_s && !in_boot |=> pend_reg[`RMC_EXT_BIT])
      else $error("external edge lost");
   a_release_align: assert property (release_now |=> phase_reg == '0 && (!clock_output || HALF == '0))
      else $error("clock output not realigned");
endmodule // rmc_top
`default_nettype wire

/* verif/rmc_sys_model.sv */
// far side model: reset pin circuit and config byte source
`timescale 1ns/1ps
`default_nettype none
module rmc_sys_model #(
   parameter logic [7:0] CCB0 = 8'h01,
   parameter logic [7:0] CCB1 = 8'h08
) (
   input wire logic ref_clk,
   input wire logic ext_rst_n,
   input wire logic slow,
   input wire logic reset_pin_oe,
   output logic reset_pin_in,
   input wire logic cfg_fetch_req,
   input wire logic cfg_fetch_index,
   output logic [7:0] cfg_fetch_data,
   output logic cfg_fetch_ack
);
   int wait_cnt = 0;
   // pulled-up open-drain pin: low while either side pulls
   assign reset_pin_in = ext_rst_n & ~reset_pin_oe;
   initial begin
      cfg_fetch_ack = 1'b0;
      cfg_fetch_data = 8'h00;
   end
   // answer a fetch at once or after three cycles; idle bus shows junk
   always @(posedge ref_clk) begin
      if (cfg_fetch_req && !cfg_fetch_ack && wait_cnt >= (slow ? 3 : 0)) begin
         cfg_fetch_ack <= 1'b1;
         cfg_fetch_data <= cfg_fetch_index ? CCB1 : CCB0;
         wait_cnt <= 0;
      end else begin
         cfg_fetch_ack <= 1'b0;
         cfg_fetch_data <= ~cfg_fetch_data;
         wait_cnt <= cfg_fetch_req ? wait_cnt + 1 : 0;
      end
   end
endmodule // rmc_sys_model
`default_nettype wire

/* verif/rmc_top_tb.sv */
// self-checking bench for the reset and mode control block
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.svh"
module rmc_top_tb;
   localparam int SC = 2;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, ext = 0, osc = 0, ext_rst_n = 0, slow = 0;
   logic [15:0] paddr = '0, ffa;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] strb = 4'hF;
   logic pready, pslverr, pin_in, oe, req, idx, ack, core_rst, ff, cpu_en, err;
   logic [7:0] cdata;
   logic emul = 1, test = 1, vpp = 1, irq, pout, pper, posc, clko, emo, tmo, flt;
   logic [7:0] p2f, p2d, p5f, p5d;
   int fails = 0, comparisons = 0, n;
   int model [int];
   logic [13:0] regs [5] = '{`RMC_IDX_P2_FSEL, `RMC_IDX_PORT2_DIRECTION, `RMC_IDX_P5_FSEL, `RMC_IDX_PORT5_DIRECTION, `RMC_IDX_MASK1};
   logic [21:0] cause [3] = '{{`RMC_IDX_SWRST, 8'hFF}, {`RMC_IDX_PMODE, 8'h03}, {`RMC_IDX_PMODE, 8'h80}};
   rmc_top #(.STATE_CYCLES(SC)) rmc_top_inst (
      .ref_clk(clk), .resetn(rstn), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(paddr),
      .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reset_pin_in(pin_in), .reset_pin_out(pout), .reset_pin_oe(oe), .ext_int_pin(ext), .vpp_pin(vpp),
      .emul_sel_pin(emul), .test_entry_pin(test), .osc_in(osc), .cfg_fetch_req(req),
      .cfg_fetch_index(idx), .cfg_fetch_data(cdata), .cfg_fetch_ack(ack), .irq_taken(1'b0),
      .other_irq_wake(1'b0), .ext_irq_request(irq), .core_reset(core_rst), .first_fetch(ff),
      .first_fetch_addr(ffa), .cpu_clk_en(cpu_en), .periph_clk_en(pper), .osc_en(posc), .clock_output(clko),
      .emulation_mode(emo), .test_mode(tmo), .pins_float(flt), .port2_function_select(p2f),
      .port2_direction(p2d), .port5_function_select(p5f), .port5_direction(p5d));
   rmc_sys_model rmc_sys_model_inst (
      .ref_clk(clk), .ext_rst_n(ext_rst_n), .slow(slow), .reset_pin_oe(oe), .reset_pin_in(pin_in),
      .cfg_fetch_req(req), .cfg_fetch_index(idx), .cfg_fetch_data(cdata), .cfg_fetch_ack(ack));
   // ----------------------------------------
   // clocks and shared tasks
   // ----------------------------------------
   initial forever #2 clk = ~clk;
   always @(posedge clk) osc <= ~osc;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; waits on pready, the watchdog cuts a hang
   task automatic apb(input logic wr, input logic [13:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= {a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // wait for the first fetch after any reset; registers start over
   task automatic boot;
      n = 0;
      while (ff !== 1'b1 && n++ < 500) @(negedge clk);
      chk(ff, 1'b1);
      chk(ffa, 16'h2080);
      chk(core_rst, 1'b0);
      model.delete();
      apb(0, `RMC_IDX_CHIP_CONFIG_ZERO, 0);
      chk(rd, 32'h01);
   endtask
   task automatic complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #80000;
      fails++;
      complete_run;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(35668));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      ext_rst_n <= 1'b1;
      boot;
      // register file against the model, then read-only and unmapped places
      foreach (regs[i]) begin
         model[i] = $urandom % 256;
         apb(1, regs[i], model[i][7:0]);
      end
      foreach (regs[i]) begin
         apb(0, regs[i], 0);
         chk(rd, model[i]);
      end
      chk({p5d, p5f, p2d, p2f}, {model[3][7:0], model[2][7:0], model[1][7:0], model[0][7:0]});
      @(negedge clk) rd = clko;
      @(negedge clk) chk(clko, !rd[0]);
      // a broken clear sequence leaves the watchdog off, a full one starts it
      apb(1, `RMC_IDX_WDT, `RMC_WDT_KEY1);
      apb(1, `RMC_IDX_MASK1, 8'h00);
      apb(1, `RMC_IDX_WDT, `RMC_WDT_KEY2);
      apb(0, `RMC_IDX_STATUS, 0);
      chk(rd[2], 1'b0);
      apb(1, `RMC_IDX_WDT, `RMC_WDT_KEY1);
      apb(1, `RMC_IDX_WDT, `RMC_WDT_KEY2);
      apb(0, `RMC_IDX_STATUS, 0);
      chk(rd[2], 1'b1);
      apb(1, `RMC_IDX_CHIP_CONFIG_ZERO, 8'h55);
      apb(0, `RMC_IDX_CHIP_CONFIG_ZERO, 0);
      chk(rd, 32'h01);
      apb(0, 14'h0100, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      // pin held high over one state time sets pending
      @(posedge clk) ext <= 1'b1;
      repeat (12) @(posedge clk);
      apb(0, `RMC_IDX_PEND1, 0);
      chk(rd & 32'h40, 32'h40);
      ext <= 1'b0;
      // idle entry, then wake by enabled external edge
      apb(1, `RMC_IDX_PEND1, 0);
      apb(1, `RMC_IDX_MASK1, 8'h40);
      apb(1, `RMC_IDX_PMODE, `RMC_KEY_IDLE);
      repeat (3) @(negedge clk);
      chk(cpu_en, 1'b0);
      @(posedge clk) ext <= 1'b1;
      n = 0;
      while (cpu_en !== 1'b1 && n++ < 100) @(negedge clk);
      chk(cpu_en, 1'b1);
      chk(irq, 1'b1);
      @(posedge clk) ext <= 1'b0;
      // internal causes: pin pulled for sixteen state times, registers cleared
      foreach (cause[i]) begin
         slow <= 1'($urandom % 2);
         apb(1, cause[i][21:8], cause[i][7:0]);
         n = 0;
         while (oe !== 1'b1 && n++ < 10) @(negedge clk);
         chk({core_rst, pout}, 2'b10);
         n = 0;
         while (oe === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
         end
         chk(n, 16 * SC);
         boot;
         apb(0, regs[1], 0);
         chk(rd, 32'h0);
         apb(0, `RMC_IDX_STATUS, 0);
         chk(rd, 32'h0);
      end
      // powerdown entry, then wake by the programming pin with the oscillator left off
      apb(1, `RMC_IDX_PMODE, `RMC_KEY_PD);
      repeat (2) @(negedge clk);
      chk({pper, posc, cpu_en, clko}, 4'b0001);
      @(posedge clk) vpp <= 1'b0;
      n = 0;
      while (cpu_en !== 1'b1 && n++ < 100) @(negedge clk);
      chk({cpu_en, posc}, 2'b10);
      @(posedge clk) vpp <= 1'b1;
      // pin reset out of idle restarts at the start address, mode pins latched low
      apb(1, `RMC_IDX_PMODE, `RMC_KEY_IDLE);
      @(posedge clk) {ext_rst_n, emul, test} <= 3'b000;
      repeat (4) @(posedge clk);
      ext_rst_n <= 1'b1;
      boot;
      chk({emo, tmo, flt}, 3'b111);
      complete_run;
   end
endmodule // rmc_top_tb
`default_nettype wire
